/* dsnz_pkg.sv */
// constants for the decrement-and-skip-unless-zero execution block
// assumes one core clock; each rising clock edge is one quarter phase of a cycle
package dsnz_pkg;
    // opcode field, instruction word bits [15:10]
    localparam logic [5:0] DSNZ_OPCODE = 6'h13;
    localparam int DSNZ_OP_LSB = 10;
    // field positions inside the instruction word
    localparam int DSNZ_DEST_BIT = 9;
    localparam int DSNZ_BANK_BIT = 8;
    // highest operand that stays in low access ram / indexed window
    localparam logic [7:0] DSNZ_LOW_LIMIT = 8'h5f;
    // bank numbers of the two halves of the fast-access bank
    localparam logic [3:0] DSNZ_ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] DSNZ_ACC_HIGH_BANK = 4'hf;
    // quarter phases per instruction cycle and no-op lengths minus one
    localparam int DSNZ_PHASES = 4;
    localparam logic [2:0] DSNZ_NOP_ONE = 3'(DSNZ_PHASES - 1);
    localparam logic [2:0] DSNZ_NOP_TWO = 3'(2 * DSNZ_PHASES - 1);
    // reset values
    localparam logic [11:0] DSNZ_ADDR_RST = 12'h000;
    localparam logic [7:0] DSNZ_DATA_RST = 8'h00;
    localparam logic [2:0] DSNZ_CNT_RST = 3'h0;
    // execution sequence, one state per quarter phase except DSNZ_NOP, held for four or eight
    typedef enum logic [2:0] {
        DSNZ_IDLE, DSNZ_READ, DSNZ_PROC, DSNZ_WRITE, DSNZ_NOP
    } dsnz_state_t;
endpackage

/* dsnz_addr.sv */
// operand address former: fast-access bank, banked, or indexed offset
// assumes the bank pointer and index base are stable during decode
`timescale 1ns/1ps
module dsnz_addr import dsnz_pkg::*; (
    // decoded operand fields
    input wire logic bank_bit,
    input wire logic [7:0] operand,
    // core state
    input wire logic [3:0] bank_pointer_register,
    input wire logic ext_enable,
    input wire logic [11:0] index_base,
    // formed address
    output logic [11:0] addr,
    output logic indexed
);
    // a=1 uses the bank pointer; otherwise, unless indexed, low operands hit bank 0 and the rest hit the special register bank
    always_comb begin
        indexed = ext_enable && !bank_bit && (operand <= DSNZ_LOW_LIMIT);
        if (bank_bit) begin
            addr = {bank_pointer_register, operand};
        end else if (indexed) begin
            // wraps within the 4k space, as the address adder does
            addr = index_base + {4'h0, operand};
        end else if (operand <= DSNZ_LOW_LIMIT) begin
            addr = {DSNZ_ACC_LOW_BANK, operand};
        end else begin
            addr = {DSNZ_ACC_HIGH_BANK, operand};
        end
    end
endmodule

/* dsnz_exec.sv */
// execution of the decrement-and-skip-unless-zero byte instruction
// assumes the core offers a word in the decode phase and reads data
// memory combinationally while mem_rd_en is high
// Notes on behaviour
// - destination 0: result to working register
// - destination 1: result back to source byte
// - decode upper six bits 010011, d, a, f
// - nonzero result discards the fetched next instruction
// - skip adds no-op cycle; four phases each
// - a=0 fast-access bank, a=1 bank pointer
// - extended, a=0, f<=95: indexed literal offset
`timescale 1ns/1ps
module dsnz_exec import dsnz_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // instruction offered in the decode phase
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic next_two_word,
    // core state used for addressing
    input wire logic [3:0] bank_pointer_register,
    input wire logic ext_enable,
    input wire logic [11:0] index_base,
    // data memory
    input wire logic [7:0] mem_rdata,
    output logic [11:0] mem_addr,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [7:0] mem_wdata,
    // working register and status
    output logic wreg_wr_en,
    output logic [7:0] wreg_wdata,
    output logic status_wr_en,
    // sequencing towards the fetch unit
    output logic busy,
    output logic discard,
    output logic nop_cycle
);
    dsnz_state_t state_reg, state_next; // quarter-phase sequence
    logic [11:0] addr_reg, addr_next; // operand address, held to write
    logic dest_reg, dest_next; // destination select
    logic two_reg, two_next; // skipped instruction is two words
    logic [7:0] data_reg, data_next; // operand as read
    logic [2:0] cnt_reg, cnt_next; // no-op phase counter
    logic rd_reg, rd_next;
    logic mwr_reg, mwr_next;
    logic [7:0] wdata_reg, wdata_next; // shared by both destinations
    logic wwr_reg, wwr_next;
    logic busy_reg, busy_next;
    logic disc_reg, disc_next;
    logic nop_reg, nop_next;
    logic stat_reg; // status flags never written by this instruction
    logic [11:0] formed_addr; // address from the former
    logic decode_go; // a matching word is taken
    logic [7:0] result; // decremented operand

    // opcode match on the top six bits
    function automatic logic dsnz_match(input logic [15:0] w);
        dsnz_match = (w[15:DSNZ_OP_LSB] == DSNZ_OPCODE);
    endfunction

    // address former, fed straight from the offered word
    dsnz_addr u_addr (
        .bank_bit(instr_word[DSNZ_BANK_BIT]),
        .operand(instr_word[7:0]),
        .bank_pointer_register(bank_pointer_register),
        .ext_enable(ext_enable),
        .index_base(index_base),
        .addr(formed_addr),
        .indexed()
    );

    // take only in the decode phase of an idle sequence
    assign decode_go = (state_reg == DSNZ_IDLE) && instr_valid &&
                       dsnz_match(instr_word);
    assign result = data_reg - 8'h01;

    // next-state and output computation
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        dest_next = dest_reg;
        two_next = two_reg;
        data_next = data_reg;
        cnt_next = cnt_reg;
        rd_next = 1'b0;
        mwr_next = 1'b0;
        wdata_next = wdata_reg;
        wwr_next = 1'b0;
        busy_next = busy_reg;
        disc_next = disc_reg;
        nop_next = nop_reg;
        unique case (state_reg)
            DSNZ_IDLE: begin
                // decode phase
                if (decode_go) begin
                    addr_next = formed_addr;
                    dest_next = instr_word[DSNZ_DEST_BIT];
                    rd_next = 1'b1;
                    busy_next = 1'b1;
                    state_next = DSNZ_READ;
                end
            end
            DSNZ_READ: begin
                // read phase: capture the operand byte
                data_next = mem_rdata;
                state_next = DSNZ_PROC;
            end
            DSNZ_PROC: begin
                // process phase: decide destination and skip
                wdata_next = result;
                mwr_next = dest_reg;
                wwr_next = !dest_reg;
                disc_next = (result != 8'h00);
                two_next = next_two_word;
                state_next = DSNZ_WRITE;
            end
            DSNZ_WRITE: begin
                // write phase; a zero result simply ends the cycle
                if (disc_reg) begin
                    nop_next = 1'b1;
                    cnt_next = two_reg ? DSNZ_NOP_TWO : DSNZ_NOP_ONE;
                    state_next = DSNZ_NOP;
                end else begin
                    busy_next = 1'b0;
                    state_next = DSNZ_IDLE;
                end
            end
            DSNZ_NOP: begin
                // one or two whole no-op cycles stand for the skipped word
                if (cnt_reg == DSNZ_CNT_RST) begin
                    nop_next = 1'b0;
                    disc_next = 1'b0;
                    busy_next = 1'b0;
                    state_next = DSNZ_IDLE;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
        endcase
    end

    // registers only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= DSNZ_IDLE;
            addr_reg <= DSNZ_ADDR_RST;
            dest_reg <= 1'b0;
            two_reg <= 1'b0;
            data_reg <= DSNZ_DATA_RST;
            cnt_reg <= DSNZ_CNT_RST;
            rd_reg <= 1'b0;
            mwr_reg <= 1'b0;
            wdata_reg <= DSNZ_DATA_RST;
            wwr_reg <= 1'b0;
            busy_reg <= 1'b0;
            disc_reg <= 1'b0;
            nop_reg <= 1'b0;
            stat_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            dest_reg <= dest_next;
            two_reg <= two_next;
            data_reg <= data_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
            mwr_reg <= mwr_next;
            wdata_reg <= wdata_next;
            wwr_reg <= wwr_next;
            busy_reg <= busy_next;
            disc_reg <= disc_next;
            nop_reg <= nop_next;
            stat_reg <= 1'b0;
        end
    end

    // outputs straight from flops
    assign mem_addr = addr_reg;
    assign mem_rd_en = rd_reg;
    assign mem_wr_en = mwr_reg;
    assign mem_wdata = wdata_reg;
    assign wreg_wr_en = wwr_reg;
    assign wreg_wdata = wdata_reg;
    assign status_wr_en = stat_reg;
    assign busy = busy_reg;
    assign discard = disc_reg;
    assign nop_cycle = nop_reg;

    // checks on the sequence
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_NO_STATUS: assert property (!status_wr_en)
        else $error("status flags written");
    AST_W_RESULT: assert property (
        wreg_wr_en |-> !mem_wr_en && wreg_wdata == $past(mem_rdata, 2) - 8'h01)
        else $error("working register result wrong");
    AST_F_RESULT: assert property (
        mem_wr_en |-> $past(mem_rd_en, 2) && mem_addr == $past(mem_addr, 2)
        && mem_wdata == $past(mem_rdata, 2) - 8'h01)
        else $error("write-back not to the read location");
    AST_DECODE: assert property (
        (!busy && instr_valid) |=> (mem_rd_en == dsnz_match($past(instr_word))))
        else $error("decode mismatch");
    AST_SKIP: assert property (
        (mem_wr_en || wreg_wr_en) |-> discard == (wdata_reg != 8'h00))
        else $error("skip decision wrong");
    AST_NOP_ONE: assert property (
        ($rose(nop_cycle) && !two_reg) |-> nop_cycle [*4] ##1 !busy)
        else $error("single no-op cycle length wrong");
    AST_NOP_TWO: assert property (
        ($rose(nop_cycle) && two_reg) |-> nop_cycle [*8] ##1 !busy)
        else $error("double no-op cycle length wrong");
    AST_BANKED: assert property (
        (decode_go && instr_word[DSNZ_BANK_BIT]) |=>
        mem_addr == {$past(bank_pointer_register), $past(instr_word[7:0])})
        else $error("banked address wrong");
    AST_INDEXED: assert property (
        (decode_go && !instr_word[DSNZ_BANK_BIT] && ext_enable &&
        instr_word[7:0] <= DSNZ_LOW_LIMIT) |=>
        mem_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])})
        else $error("indexed address wrong");

    COV_ZERO: cover property (mem_wr_en && !discard);
    COV_SKIP1: cover property ($rose(nop_cycle) && !two_reg);
    COV_SKIP2: cover property ($rose(nop_cycle) && two_reg);
    COV_WREG: cover property (wreg_wr_en && discard);
endmodule

/* dsnz_exec_tb_top.sv */
// self-checking bench for the decrement-and-skip-unless-zero block
// assumes the block alone, memory read data served by the bench
`timescale 1ns/1ps
module dsnz_exec_tb_top import dsnz_pkg::*; ;
    // clock and reset
    logic core_clk;
    logic rst;
    // instruction side
    logic instr_valid;
    logic [15:0] instr_word;
    logic next_two_word;
    // addressing state
    logic [3:0] bank_pointer_register;
    logic ext_enable;
    logic [11:0] index_base;
    // memory and results
    logic [7:0] mem_rdata;
    logic [11:0] mem_addr;
    logic mem_rd_en, mem_wr_en, wreg_wr_en, status_wr_en;
    logic [7:0] mem_wdata, wreg_wdata;
    logic busy, discard, nop_cycle;
    // run counters
    int fails = 0;
    int compares = 0;

    dsnz_exec u_dsnz_exec (
        .core_clk(core_clk), .rst(rst),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .next_two_word(next_two_word),
        .bank_pointer_register(bank_pointer_register),
        .ext_enable(ext_enable), .index_base(index_base),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
        .mem_wdata(mem_wdata), .wreg_wr_en(wreg_wr_en),
        .wreg_wdata(wreg_wdata), .status_wr_en(status_wr_en),
        .busy(busy), .discard(discard), .nop_cycle(nop_cycle)
    );

    // 4 ns core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // verdict and end of run
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one comparison, four-state exact
    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // inputs move 1 ns after the rising edge
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    // one instruction from offer to end of sequence, judged throughout
    task automatic do_op(input logic d, input logic a, input logic [7:0] f,
                         input logic [7:0] rd, input logic two,
                         input logic [11:0] ea);
        int n;
        int nops;
        int skip;
        logic [7:0] res;
        res = rd - 8'h01;
        skip = (res == 8'h00) ? 0 : (two ? 2 : 1);
        instr_word = {DSNZ_OPCODE, d, a, f};
        instr_valid = 1'b1;
        mem_rdata = rd;
        next_two_word = two;
        tick;
        instr_valid = 1'b0;
        chk("busy", 16'(busy), 16'h0001);
        chk("mem_rd_en", 16'(mem_rd_en), 16'h0001);
        chk("mem_addr", 16'(mem_addr), 16'(ea));
        tick;
        // read data gone once the read phase is over
        mem_rdata = ~rd;
        tick;
        chk("wreg_wr_en", 16'(wreg_wr_en), 16'(!d));
        chk("mem_wr_en", 16'(mem_wr_en), 16'(d));
        chk("wdata", 16'(d ? mem_wdata : wreg_wdata), 16'(res));
        chk("status_wr_en", 16'(status_wr_en), 16'h0000);
        chk("discard", 16'(discard), 16'(skip != 0));
        n = 0;
        nops = 0;
        do begin
            tick;
            n++;
            if (busy === 1'b1 && nop_cycle === 1'b1) begin
                nops++;
            end
        end while (busy !== 1'b0 && n < 20);
        if (n >= 20) begin
            fails++;
            end_of_test;
        end
        chk("nop_phases", 16'(nops), 16'(4 * skip));
        chk("cycles", 16'(n), 16'(1 + 4 * skip));
        chk("discard_end", 16'(discard), 16'h0000);
        next_two_word = 1'b0;
    endtask

    // working register target, low access bank, skip taken
    task automatic t_wreg_skip;
        bank_pointer_register = 4'h7;
        ext_enable = 1'b0;
        do_op(1'b0, 1'b0, 8'h10, 8'h05, 1'b0, 12'h010);
    endtask

    // memory target via bank pointer, zero result then wrap, back to back
    task automatic t_mem_b2b;
        bank_pointer_register = 4'h3;
        do_op(1'b1, 1'b1, 8'ha0, 8'h01, 1'b0, 12'h3a0);
        do_op(1'b1, 1'b1, 8'h00, 8'h00, 1'b0, 12'h300);
    endtask

    // high access bank with a two-word follower
    task automatic t_two_word;
        do_op(1'b0, 1'b0, 8'h80, 8'h80, 1'b1, 12'hf80);
    endtask

    // indexed window edge, just above it, and banked with extended on
    task automatic t_indexed;
        ext_enable = 1'b1;
        index_base = 12'hff0;
        do_op(1'b1, 1'b0, 8'h5f, 8'h02, 1'b0, 12'h04f);
        do_op(1'b0, 1'b0, 8'h60, 8'h01, 1'b0, 12'hf60);
        do_op(1'b0, 1'b1, 8'h20, 8'h09, 1'b1, 12'h320);
        ext_enable = 1'b0;
    endtask

    // a neighbouring opcode must start nothing
    task automatic t_reject;
        instr_word = {DSNZ_OPCODE ^ 6'h01, 10'h3ff};
        instr_valid = 1'b1;
        repeat (3) begin
            tick;
            chk("busy_other", 16'(busy), 16'h0000);
            chk("rd_other", 16'(mem_rd_en), 16'h0000);
        end
        instr_valid = 1'b0;
    endtask

    // reset in the write phase of a skipping instruction, then run again
    task automatic t_mid_reset;
        bank_pointer_register = 4'h5;
        instr_word = {DSNZ_OPCODE, 1'b1, 1'b1, 8'h44};
        instr_valid = 1'b1;
        mem_rdata = 8'h07;
        tick;
        instr_valid = 1'b0;
        tick;
        tick;
        chk("pre_rst_wr", 16'(mem_wr_en), 16'h0001);
        chk("pre_rst_disc", 16'(discard), 16'h0001);
        // asynchronous: outputs clear without waiting for an edge
        rst = 1'b1;
        #1;
        chk("rst_busy", 16'(busy), 16'h0000);
        chk("rst_disc", 16'(discard), 16'h0000);
        chk("rst_wr", 16'(mem_wr_en), 16'h0000);
        chk("rst_addr", 16'(mem_addr), 16'(DSNZ_ADDR_RST));
        repeat (2) tick;
        rst = 1'b0;
        tick;
        chk("rel_busy", 16'(busy), 16'h0000);
        chk("rel_nop", 16'(nop_cycle), 16'h0000);
        do_op(1'b0, 1'b1, 8'h44, 8'h01, 1'b0, 12'h544);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        next_two_word = 1'b0;
        bank_pointer_register = 4'h0;
        ext_enable = 1'b0;
        index_base = 12'h000;
        mem_rdata = 8'h00;
        repeat (5) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_wreg_skip;
        t_mem_b2b;
        t_two_word;
        t_indexed;
        t_reject;
        t_mid_reset;
        end_of_test;
    end
endmodule
